// >>> src/scp_device.sv
// Device end: serial configuration port slave with register map.
// Assumes link pins arrive asynchronously and are synchronised to sys_clk_i.
// Function
// - Instruction bit 7: one reads, zero writes
// - Low seven bits give starting register address
// - Sample input bits on rising serial clock
// - Launch read bits on falling serial clock
// - Host keeps serial clock at most 40MHz
// - Select high tristates both data pins
// - Host holds select low whole cycle
// - Comm bit 7 picks bidirectional pin, reset zero
// - Separate output used unless bidirectional mode
// - Comm bit 6 picks LSB-first, reset zero
// - Instruction and data shift in chosen order
// - MSB-first multibyte address decrements
// - LSB-first multibyte address increments
// - Host MSB-first starts at top byte
// - Host LSB-first starts at bottom byte
// - Select high then low restarts instruction
// - First eight edges form instruction byte
// - Register updates at byte's last bit
`default_nettype none
module scp_device (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  scp_link_if.device link,
  input wire logic [7:0] event_flags_a_i,
  input wire logic [7:0] event_flags_b_i,
  input wire logic synth_locked_i,
  input wire logic [7:0] synth_status_a_i,
  input wire logic [7:0] synth_status_b_i,
  output logic [7:0] comm_config_o,
  output logic [7:0] power_control_o,
  output logic [7:0] input_format_o,
  output logic [7:0] event_enable_a_o,
  output logic [7:0] event_enable_b_o,
  output logic [7:0] clock_input_control_o,
  output logic [7:0] synth_control_a_o,
  output logic [7:0] synth_control_b_o,
  output logic [7:0] synth_control_c_o
);
  logic [1:0] sel_sync_ff, sclk_sync_ff, sdi_sync_ff;
  logic sclk_prev_ff;
  logic [3:0] bit_cnt_ff;
  logic instr_done_ff;
  logic read_ff;
  logic [6:0] addr_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic sdo_ff;
  logic sdio_oe_ff;
  logic sep_oe_ff;
  logic [7:0] rd_word;
  localparam logic [3:0] LAST_BIT = 4'(scp_pkg::INSTR_BITS - 1);
  logic [7:0] comm_ff, power_ff, format_ff, ena_ff, enb_ff, clkc_ff, sca_ff, scb_ff, scc_ff;

  wire sel_n = sel_sync_ff[1];
  wire sclk_s = sclk_sync_ff[1];
  wire sdi = sdi_sync_ff[1];
  wire rise = sclk_s & ~sclk_prev_ff & ~sel_n;
  wire fall = ~sclk_s & sclk_prev_ff & ~sel_n;
  wire lsb_first = comm_ff[scp_pkg::LSB_FIRST_BIT];
  wire bidir = comm_ff[scp_pkg::BIDIR_BIT];
  // Shift in at the end chosen by the bit order
  wire [7:0] shifted = lsb_first ? {sdi, shift_ff[7:1]} : {shift_ff[6:0], sdi};
  wire byte_end = rise & (bit_cnt_ff == LAST_BIT);
  wire [6:0] next_addr = lsb_first ? addr_ff + 7'h01 : addr_ff - 7'h01;
  wire [6:0] start_addr = shifted[6:0];
  wire start_read = shifted[scp_pkg::RW_BIT];
  wire [6:0] rd_addr = instr_done_ff ? next_addr : start_addr;
  wire wr_en = byte_end & instr_done_ff & ~read_ff;
  wire tx_bit = lsb_first ? tx_ff[0] : tx_ff[7];
  wire load = byte_end & (instr_done_ff ? read_ff : start_read);
  wire launch = fall & instr_done_ff & read_ff;

  function automatic logic [7:0] read_reg(input logic [6:0] a);
    case (a)
      scp_pkg::REG_COMM_CONFIG: read_reg = comm_ff;
      scp_pkg::REG_POWER_CONTROL: read_reg = {power_ff[7:1], synth_locked_i};
      scp_pkg::REG_INPUT_FORMAT: read_reg = format_ff;
      scp_pkg::REG_EVENT_ENABLE_A: read_reg = ena_ff;
      scp_pkg::REG_EVENT_ENABLE_B: read_reg = enb_ff;
      scp_pkg::REG_EVENT_FLAGS_A: read_reg = event_flags_a_i;
      scp_pkg::REG_EVENT_FLAGS_B: read_reg = event_flags_b_i & scp_pkg::MASK_EVENT_ENABLE_B;
      scp_pkg::REG_CLOCK_INPUT_CONTROL: read_reg = clkc_ff;
      scp_pkg::REG_SYNTH_CONTROL_A: read_reg = sca_ff;
      scp_pkg::REG_SYNTH_CONTROL_B: read_reg = scb_ff;
      scp_pkg::REG_SYNTH_CONTROL_C: read_reg = scc_ff;
      scp_pkg::REG_SYNTH_STATUS_A: read_reg = synth_status_a_i;
      scp_pkg::REG_SYNTH_STATUS_B: read_reg = synth_status_b_i;
      default: read_reg = 8'h00;
    endcase
  endfunction

  function automatic logic hit(input logic [6:0] a, input logic [6:0] r);
    hit = wr_en & (a == r);
  endfunction

  // Word for the next read byte; a process so that register changes retrigger it
  always_comb begin
    rd_word = read_reg(rd_addr);
  end

  // Synchronisers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sel_sync_ff <= 2'h3;
      sclk_sync_ff <= 2'h0;
      sdi_sync_ff <= 2'h0;
      sclk_prev_ff <= 1'b0;
    end else begin
      sel_sync_ff <= {sel_sync_ff[0], link.sel_n};
      sclk_sync_ff <= {sclk_sync_ff[0], link.sclk};
      sdi_sync_ff <= {sdi_sync_ff[0], link.sdio_in};
      sclk_prev_ff <= sclk_s;
    end
  end

  // Frame sequencing
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || sel_n) begin
      bit_cnt_ff <= 4'h0;
      instr_done_ff <= 1'b0;
      read_ff <= 1'b0;
      addr_ff <= scp_pkg::ADDR_MIN;
      shift_ff <= 8'h00;
    end else if (rise) begin
      shift_ff <= shifted;
      bit_cnt_ff <= (bit_cnt_ff == LAST_BIT) ? 4'h0 : bit_cnt_ff + 4'h1;
      if (byte_end && !instr_done_ff) begin
        instr_done_ff <= 1'b1;
        read_ff <= start_read;
        addr_ff <= start_addr;
      end else if (byte_end) begin
        addr_ff <= next_addr;
      end
    end
  end

  // Read shifter: loaded at byte boundary, bits launched on falling edges
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || sel_n) begin
      tx_ff <= 8'h00;
      sdo_ff <= 1'b0;
    end else if (load) begin
      tx_ff <= rd_word;
    end else if (launch) begin
      sdo_ff <= tx_bit;
      tx_ff <= lsb_first ? {1'b0, tx_ff[7:1]} : {tx_ff[6:0], 1'b0};
    end
  end

  // Output enables: raised at the first launch, dropped while deselected
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || sel_n) begin
      sdio_oe_ff <= 1'b0;
      sep_oe_ff <= 1'b0;
    end else if (launch) begin
      sdio_oe_ff <= bidir;
      sep_oe_ff <= ~bidir;
    end
  end

  // Register file
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      comm_ff <= scp_pkg::RST_COMM_CONFIG;
      power_ff <= scp_pkg::RST_POWER_CONTROL;
      format_ff <= scp_pkg::RST_INPUT_FORMAT;
      ena_ff <= scp_pkg::RST_EVENT_ENABLE;
      enb_ff <= scp_pkg::RST_EVENT_ENABLE;
      clkc_ff <= scp_pkg::RST_CLOCK_INPUT_CONTROL;
      sca_ff <= scp_pkg::RST_SYNTH_CONTROL_A;
      scb_ff <= scp_pkg::RST_SYNTH_CONTROL_B;
      scc_ff <= scp_pkg::RST_SYNTH_CONTROL_C;
    end else begin
      if (hit(addr_ff, scp_pkg::REG_COMM_CONFIG)) comm_ff <= shifted & scp_pkg::MASK_COMM_CONFIG;
      if (hit(addr_ff, scp_pkg::REG_POWER_CONTROL)) power_ff <= shifted & scp_pkg::MASK_POWER_CONTROL;
      if (hit(addr_ff, scp_pkg::REG_INPUT_FORMAT)) format_ff <= shifted;
      if (hit(addr_ff, scp_pkg::REG_EVENT_ENABLE_A)) ena_ff <= shifted;
      if (hit(addr_ff, scp_pkg::REG_EVENT_ENABLE_B)) enb_ff <= shifted & scp_pkg::MASK_EVENT_ENABLE_B;
      if (hit(addr_ff, scp_pkg::REG_CLOCK_INPUT_CONTROL)) begin
        clkc_ff <= (shifted & scp_pkg::MASK_CLOCK_INPUT_CONTROL) | scp_pkg::FIXED_CLOCK_INPUT_CONTROL;
      end
      if (hit(addr_ff, scp_pkg::REG_SYNTH_CONTROL_A)) sca_ff <= shifted;
      if (hit(addr_ff, scp_pkg::REG_SYNTH_CONTROL_B)) scb_ff <= shifted;
      if (hit(addr_ff, scp_pkg::REG_SYNTH_CONTROL_C)) scc_ff <= shifted;
    end
  end

  // Pin drive
  always_comb begin
    link.sdio_dev_o = sdo_ff;
    link.sdio_dev_oe = sdio_oe_ff;
    link.separate_out_pin_o = sdo_ff;
    link.separate_out_pin_oe = sep_oe_ff;
  end

  assign comm_config_o = comm_ff;
  assign power_control_o = power_ff;
  assign input_format_o = format_ff;
  assign event_enable_a_o = ena_ff;
  assign event_enable_b_o = enb_ff;
  assign clock_input_control_o = clkc_ff;
  assign synth_control_a_o = sca_ff;
  assign synth_control_b_o = scb_ff;
  assign synth_control_c_o = scc_ff;
endmodule
`default_nettype wire

// >>> src/scp_host.sv
// Host end: serial master driven through a small register port.
// Assumes software sets count, mode and data before writing the command.
`default_nettype none
module scp_host #(
  parameter int unsigned HALF_CYCLES = scp_pkg::HOST_HALF_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  scp_link_if.host link,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic busy_o
);
  typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_SHIFT = 2'b01, HS_DONE = 2'b11} scp_hstate_type;
  scp_hstate_type state_ff;
  logic [7:0] cmd_ff, count_ff, mode_ff, wdata_ff, rdata_ff, rdout_ff;
  logic [7:0] tx_ff, rx_ff;
  logic [7:0] remain_ff;
  logic [2:0] bit_ff;
  logic instr_ff;
  logic [7:0] div_ff;
  logic sclk_ff, sel_n_ff, oe_ff;
  logic [1:0] sdio_sync_ff, sep_sync_ff;
  localparam logic [2:0] LAST_BIT = 3'(scp_pkg::INSTR_BITS - 1);
  wire lsb_first = mode_ff[scp_pkg::LSB_FIRST_BIT];
  wire bidir = mode_ff[scp_pkg::BIDIR_BIT];
  wire is_read = cmd_ff[scp_pkg::RW_BIT];
  wire tick = (div_ff == 8'(HALF_CYCLES - 1));
  wire sdi = bidir ? sdio_sync_ff[1] : sep_sync_ff[1];
  wire [7:0] rx_next = lsb_first ? {sdi, rx_ff[7:1]} : {rx_ff[6:0], sdi};
  wire start = wr_i & (addr_i == scp_pkg::HOST_REG_CMD) & (state_ff == HS_IDLE);
  wire last_bit = (bit_ff == LAST_BIT);

  // Puts the first bit to send in bit 7 whatever the bit order
  function automatic logic [7:0] wire_order(input logic [7:0] b, input logic lsb);
    for (int i = 0; i < scp_pkg::DATA_W; i++) begin
      wire_order[i] = lsb ? b[scp_pkg::DATA_W - 1 - i] : b[i];
    end
  endfunction

  // Each return pin is synchronised on its own before selection
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sdio_sync_ff <= 2'h0;
      sep_sync_ff <= 2'h0;
    end else begin
      sdio_sync_ff <= {sdio_sync_ff[0], link.sdio_in};
      sep_sync_ff <= {sep_sync_ff[0], link.separate_out_pin_in};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      count_ff <= 8'h00;
      mode_ff <= 8'h00;
      wdata_ff <= 8'h00;
    end else if (wr_i) begin
      if (addr_i == scp_pkg::HOST_REG_COUNT) count_ff <= wdata_i;
      if (addr_i == scp_pkg::HOST_REG_MODE) mode_ff <= wdata_i;
      if (addr_i == scp_pkg::HOST_REG_WDATA) wdata_ff <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) rdout_ff <= 8'h00;
    else if (rd_i) begin
      case (addr_i)
        scp_pkg::HOST_REG_CMD: rdout_ff <= cmd_ff;
        scp_pkg::HOST_REG_COUNT: rdout_ff <= count_ff;
        scp_pkg::HOST_REG_MODE: rdout_ff <= mode_ff;
        scp_pkg::HOST_REG_STATUS: rdout_ff <= {7'h00, state_ff != HS_IDLE};
        scp_pkg::HOST_REG_WDATA: rdout_ff <= wdata_ff;
        scp_pkg::HOST_REG_RDATA: rdout_ff <= rdata_ff;
        default: rdout_ff <= 8'h00;
      endcase
    end else rdout_ff <= 8'h00;
  end

  // One byte per transfer for the data phase; count gives data bytes
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_ff <= HS_IDLE;
      cmd_ff <= 8'h00;
      tx_ff <= 8'h00;
      rx_ff <= 8'h00;
      rdata_ff <= 8'h00;
      remain_ff <= 8'h00;
      bit_ff <= 3'h0;
      instr_ff <= 1'b0;
      div_ff <= 8'h00;
      sclk_ff <= 1'b0;
      sel_n_ff <= 1'b1;
      oe_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        HS_IDLE: begin
          if (start) begin
            cmd_ff <= wdata_i;
            tx_ff <= wire_order(wdata_i, lsb_first);
            remain_ff <= count_ff;
            bit_ff <= 3'h0;
            instr_ff <= 1'b1;
            div_ff <= 8'h00;
            sel_n_ff <= 1'b0;
            oe_ff <= 1'b1;
            state_ff <= HS_SHIFT;
          end
        end
        HS_SHIFT: begin
          div_ff <= tick ? 8'h00 : div_ff + 8'h01;
          if (tick && !sclk_ff) begin
            sclk_ff <= 1'b1;
          end else if (tick) begin
            // Read bits taken at the end of the high phase, past both synchroniser delays
            sclk_ff <= 1'b0;
            rx_ff <= rx_next;
            bit_ff <= bit_ff + 3'h1;
            tx_ff <= {tx_ff[6:0], 1'b0};
            if (last_bit) begin
              if (!instr_ff && is_read) rdata_ff <= rx_next;
              tx_ff <= wire_order(wdata_ff, lsb_first);
              oe_ff <= ~is_read;
              instr_ff <= 1'b0;
              if (remain_ff == 8'h00 || (!instr_ff && remain_ff == 8'h01)) state_ff <= HS_DONE;
              else if (!instr_ff) remain_ff <= remain_ff - 8'h01;
            end
          end
        end
        HS_DONE: begin
          sel_n_ff <= 1'b1;
          oe_ff <= 1'b0;
          state_ff <= HS_IDLE;
        end
        default: state_ff <= HS_IDLE;
      endcase
    end
  end

  always_comb begin
    link.sel_n = sel_n_ff;
    link.sclk = sclk_ff;
    link.sdio_host_o = tx_ff[7];
    link.sdio_host_oe = oe_ff;
  end
  assign rdata_o = rdout_ff;
  // Bit 0 of the state code is set in every busy state
  assign busy_o = state_ff[0];
endmodule
`default_nettype wire

// >>> src/scp_link_if.sv
// Interface: the four serial wires between host and device.
// Assumes the testbench resolves the shared data wire from the enables.
`default_nettype none
interface scp_link_if;
  logic sel_n;
  logic sclk;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic sdio_in;
  logic separate_out_pin_o;
  logic separate_out_pin_oe;
  logic separate_out_pin_in;
  modport device (input sel_n, input sclk, input sdio_in, input separate_out_pin_in,
    output sdio_dev_o, output sdio_dev_oe, output separate_out_pin_o, output separate_out_pin_oe);
  modport host (output sel_n, output sclk, output sdio_host_o, output sdio_host_oe,
    input sdio_in, input separate_out_pin_in);
endinterface
`default_nettype wire

// >>> src/scp_pkg.sv
// Package: constants shared by both ends of the serial configuration port.
// Assumes a 20 MHz system clock on both ends.
`default_nettype none
package scp_pkg;
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned INSTR_BITS = 8;
  localparam int unsigned RW_BIT = 7;
  localparam logic [6:0] ADDR_MIN = 7'h00;
  localparam logic [6:0] ADDR_MAX = 7'h7F;
  localparam logic [6:0] REG_COMM_CONFIG = 7'h00;
  localparam logic [6:0] REG_POWER_CONTROL = 7'h01;
  localparam logic [6:0] REG_INPUT_FORMAT = 7'h03;
  localparam logic [6:0] REG_EVENT_ENABLE_A = 7'h04;
  localparam logic [6:0] REG_EVENT_ENABLE_B = 7'h05;
  localparam logic [6:0] REG_EVENT_FLAGS_A = 7'h06;
  localparam logic [6:0] REG_EVENT_FLAGS_B = 7'h07;
  localparam logic [6:0] REG_CLOCK_INPUT_CONTROL = 7'h08;
  localparam logic [6:0] REG_SYNTH_CONTROL_A = 7'h0A;
  localparam logic [6:0] REG_SYNTH_CONTROL_B = 7'h0C;
  localparam logic [6:0] REG_SYNTH_CONTROL_C = 7'h0D;
  localparam logic [6:0] REG_SYNTH_STATUS_A = 7'h0E;
  localparam logic [6:0] REG_SYNTH_STATUS_B = 7'h0F;
  localparam int unsigned BIDIR_BIT = 7;
  localparam int unsigned LSB_FIRST_BIT = 6;
  localparam logic [7:0] RST_COMM_CONFIG = 8'h00;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h10;
  localparam logic [7:0] RST_INPUT_FORMAT = 8'h00;
  localparam logic [7:0] RST_EVENT_ENABLE = 8'h00;
  localparam logic [7:0] RST_CLOCK_INPUT_CONTROL = 8'h3F;
  localparam logic [7:0] RST_SYNTH_CONTROL_A = 8'h00;
  localparam logic [7:0] RST_SYNTH_CONTROL_B = 8'hD1;
  localparam logic [7:0] RST_SYNTH_CONTROL_C = 8'hD9;
  localparam logic [7:0] MASK_COMM_CONFIG = 8'hE0;
  localparam logic [7:0] MASK_POWER_CONTROL = 8'hF0;
  localparam logic [7:0] MASK_EVENT_ENABLE_B = 8'h1C;
  localparam logic [7:0] MASK_CLOCK_INPUT_CONTROL = 8'hF0;
  localparam logic [7:0] FIXED_CLOCK_INPUT_CONTROL = 8'h0F;
  localparam int unsigned LINK_MAX_HZ = 40_000_000;
  // Half period of the host-generated link clock, in system cycles
  localparam int unsigned HOST_HALF_CYCLES = 4;
  localparam logic [1:0] HOST_CMD_WRITE = 2'h0;
  localparam logic [1:0] HOST_CMD_READ = 2'h1;
  localparam logic [7:0] HOST_REG_CMD = 8'h00;
  localparam logic [7:0] HOST_REG_COUNT = 8'h01;
  localparam logic [7:0] HOST_REG_MODE = 8'h02;
  localparam logic [7:0] HOST_REG_STATUS = 8'h03;
  localparam logic [7:0] HOST_REG_WDATA = 8'h04;
  localparam logic [7:0] HOST_REG_RDATA = 8'h05;
endpackage
`default_nettype wire

// >>> testbench/scp_link_assertions.sv
// Checker: timing of the four link wires between host and device.
// Assumes the host link clock half period of four system cycles.
`default_nettype none
module scp_link_assertions (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdio_host_o,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_o,
  input wire logic sdio_dev_oe,
  input wire logic separate_out_pin_o,
  input wire logic separate_out_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclk_ff;
  logic [7:0] rise_cnt_ff;
  logic [7:0] nxt_rise_cnt;
  wire rise_w = sclk && !sclk_ff;
  assign nxt_rise_cnt = sel_n ? 8'h00 : rise_cnt_ff + {7'h00, rise_w};
  always_ff @(posedge sys_clk_i) begin
    sclk_ff <= sclk;
    rise_cnt_ff <= reset_i ? 8'h00 : nxt_rise_cnt;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_high_run;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_quiet_start;
    !sclk [*2];
  endsequence
  property p_idle_hiz;
    sel_n [*4] |-> !sdio_dev_oe && !separate_out_pin_oe;
  endproperty
  property p_one_driver;
    !(sdio_host_oe && sdio_dev_oe);
  endproperty
  property p_clk_idle;
    sel_n |-> !sclk;
  endproperty
  property p_clk_high;
    $rose(sclk) |-> s_high_run;
  endproperty
  property p_frame_open;
    $fell(sel_n) |-> s_quiet_start;
  endproperty
  property p_dev_launch;
    separate_out_pin_oe && $past(separate_out_pin_oe) && $changed(separate_out_pin_o) |-> !sclk;
  endproperty
  property p_dev_launch_bidir;
    sdio_dev_oe && $past(sdio_dev_oe) && $changed(sdio_dev_o) |-> !sclk;
  endproperty
  property p_host_setup;
    sdio_host_oe && $changed(sdio_host_o) |-> !sclk;
  endproperty
  property p_instr_first;
    $rose(sdio_dev_oe || separate_out_pin_oe) |-> rise_cnt_ff == 8'h08;
  endproperty
  property p_whole_bytes;
    $rose(sel_n) |-> rise_cnt_ff[2:0] == 3'h0 && rise_cnt_ff >= 8'h10;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("data pin driven while deselected");
  a_one_driver: assert property (p_one_driver) else $error("both ends drive the data wire");
  a_clk_idle: assert property (p_clk_idle) else $error("link clock high while deselected");
  a_clk_high: assert property (p_clk_high) else $error("link clock high phase wrong length");
  a_frame_open: assert property (p_frame_open) else $error("link clock rose too soon after select");
  a_dev_launch: assert property (p_dev_launch) else $error("read bit changed while clock high");
  a_dev_launch_bidir: assert property (p_dev_launch_bidir) else $error("shared read bit changed while clock high");
  a_host_setup: assert property (p_host_setup) else $error("write bit changed while clock high");
  a_instr_first: assert property (p_instr_first) else $error("read data before eighth rise");
  a_whole_bytes: assert property (p_whole_bytes) else $error("frame not whole bytes");
endmodule
`default_nettype wire

// >>> testbench/test_serial_config_port.sv
// Testbench: host and device joined over the link, run through the host register port.
// Assumes one 20 MHz clock for both ends; the shared data wire idles high.
`default_nettype none
module test_serial_config_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, fa = 8'h00, fb = 8'h00, s_a = 8'h00, s_b = 8'h00;
  logic wr = 1'b0, rd = 1'b0, trk = 1'b0, rd_d = 1'b0, trk_d = 1'b0, lock = 1'b0, busy;
  logic [7:0] rdata, comm, pwr, fmt, ena, enb, clkc, sa, sb, sc, r1, r2, r3;
  logic [31:0] seed = 32'h22;
  logic [7:0] exp_q[$];
  int failures = 0;
  int tests_run = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  scp_link_if link ();
  assign link.sdio_in = link.sdio_host_oe ? link.sdio_host_o : (link.sdio_dev_oe ? link.sdio_dev_o : 1'b1);
  assign link.separate_out_pin_in = link.separate_out_pin_oe ? link.separate_out_pin_o : 1'b1;
  scp_host scp_host_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(link.host), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .busy_o(busy));
  scp_device scp_device_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(link.device),
    .event_flags_a_i(fa), .event_flags_b_i(fb), .synth_locked_i(lock), .synth_status_a_i(s_a),
    .synth_status_b_i(s_b), .comm_config_o(comm), .power_control_o(pwr), .input_format_o(fmt),
    .event_enable_a_o(ena), .event_enable_b_o(enb), .clock_input_control_o(clkc),
    .synth_control_a_o(sa), .synth_control_b_o(sb), .synth_control_c_o(sc));
  scp_link_assertions scp_link_assertions_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .sel_n(link.sel_n), .sclk(link.sclk), .sdio_host_o(link.sdio_host_o), .sdio_host_oe(link.sdio_host_oe),
    .sdio_dev_o(link.sdio_dev_o), .sdio_dev_oe(link.sdio_dev_oe), .separate_out_pin_o(link.separate_out_pin_o),
    .separate_out_pin_oe(link.separate_out_pin_oe));
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w, input logic t);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    trk <= t;
    @(posedge sys_clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    trk <= 1'b0;
  endtask
  task automatic rdq(input logic [7:0] e);
    exp_q.push_back(e);
    bus(scp_pkg::HOST_REG_RDATA, 8'h00, 1'b0, 1'b1);
  endtask
  task automatic xfer(input logic [7:0] instr, input logic [7:0] cnt, input logic [7:0] mode, input logic [7:0] d);
    int n;
    bus(scp_pkg::HOST_REG_COUNT, cnt, 1'b1, 1'b0);
    bus(scp_pkg::HOST_REG_MODE, mode, 1'b1, 1'b0);
    bus(scp_pkg::HOST_REG_WDATA, d, 1'b1, 1'b0);
    bus(scp_pkg::HOST_REG_CMD, instr, 1'b1, 1'b0);
    n = 0;
    repeat (2) @(posedge sys_clk_i);
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge sys_clk_i);
      n++;
    end
    check("busy", 8'h00, {7'h00, busy});
    repeat (8) @(posedge sys_clk_i);
  endtask
  // Result monitor: tracked host reads against the oldest note
  always @(posedge sys_clk_i) begin
    rd_d <= rd;
    trk_d <= trk;
    if (rd_d && trk_d) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("ERROR rdata expected none seen %h", rdata);
      end else begin
        check("rdata", exp_q.pop_front(), rdata);
      end
    end
  end
  initial begin
    #1000000;
    failures++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    fa <= rnd();
    fb <= rnd();
    s_a <= rnd();
    s_b <= rnd();
    lock <= ^rnd();
    @(posedge sys_clk_i);
    check("comm", 8'h00, comm);
    check("power", 8'h10, pwr);
    check("clkc", 8'h3F, clkc);
    check("synth_c", 8'hD9, sc);
    check("format", 8'h00, fmt);
    check("synth_a", 8'h00, sa);
    r1 = rnd();
    xfer({1'b0, scp_pkg::REG_SYNTH_CONTROL_B}, 8'h01, 8'h00, r1);
    check("synth_b", r1, sb);
    xfer({1'b1, scp_pkg::REG_SYNTH_CONTROL_B}, 8'h01, 8'h00, 8'h00);
    rdq(r1);
    r2 = rnd();
    xfer({1'b0, scp_pkg::REG_SYNTH_CONTROL_C}, 8'h03, 8'h00, r2);
    check("synth_c", r2, sc);
    check("synth_b", r2, sb);
    xfer({1'b1, scp_pkg::REG_SYNTH_CONTROL_C}, 8'h02, 8'h00, 8'h00);
    rdq(r2);
    xfer({1'b0, scp_pkg::REG_EVENT_FLAGS_A}, 8'h01, 8'h00, ~fa);
    xfer({1'b1, scp_pkg::REG_EVENT_FLAGS_A}, 8'h01, 8'h00, 8'h00);
    rdq(fa);
    xfer({1'b1, scp_pkg::REG_EVENT_FLAGS_B}, 8'h01, 8'h00, 8'h00);
    rdq(fb & 8'h1C);
    xfer({1'b1, scp_pkg::REG_SYNTH_STATUS_B}, 8'h02, 8'h00, 8'h00);
    rdq(s_a);
    xfer({1'b0, scp_pkg::REG_POWER_CONTROL}, 8'h01, 8'h00, 8'hFF);
    check("power", 8'hF0, pwr);
    xfer({1'b1, scp_pkg::REG_POWER_CONTROL}, 8'h01, 8'h00, 8'h00);
    rdq({7'h78, lock});
    xfer({1'b0, scp_pkg::REG_COMM_CONFIG}, 8'h01, 8'h00, 8'hC0);
    check("comm", 8'hC0, comm);
    r3 = rnd();
    xfer({1'b0, scp_pkg::REG_EVENT_ENABLE_A}, 8'h02, 8'hC0, r3);
    check("enable_a", r3, ena);
    check("enable_b", r3 & 8'h1C, enb);
    xfer({1'b1, scp_pkg::REG_EVENT_ENABLE_A}, 8'h02, 8'hC0, 8'h00);
    rdq(r3 & 8'h1C);
    repeat (4) @(posedge sys_clk_i);
    conclude();
  end
endmodule
`default_nettype wire
